/* File: logic/etm_pkg.sv */
package etm_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_COUNT = 8'h0d;
    localparam logic [7:0] ADDR_CTRL = 8'h0e;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h11;

    // ************************************************************
    // control field positions and reset values
    // ************************************************************
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_RUN_BIT = 4;
    localparam int CTRL_EDGE_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [7:0] CTRL_WMASK = 8'hdf;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_MEAS_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // ************************************************************
    // modes
    // ************************************************************
    localparam logic [1:0] MODE_UNUSED = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;

    // pulse measurement phases, one-hot
    typedef enum logic [2:0] {
        ETM_ARMED = 3'h1,
        ETM_MEASURE = 3'h2,
        ETM_DONE = 3'h4
    } etm_meas_e;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } etm_req_s;

    // whole block state
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] preload;
        logic [7:0] ctrl;
        logic [7:0] presc;
        logic [7:0] rdata;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic pin_prev;
        logic tick_prev;
        logic freq_out;
        logic ovf_flag;
        logic wake;
        etm_meas_e meas;
    } etm_state_s;

endpackage : etm_pkg

/* File: logic/etm_timer.sv */
// Summary of operation
// - eight-bit up-counter clocked by pin or prescaled tick, per mode
// - divided output runs at the counting clock (pin edge or tick) over twice (256 minus preload)
// - count at 0d, control at 0e; write preloads, read returns live count
// - control bits 7:6 pick mode: 01 event, 10 timer, 11 pulse
// - event and timer count to ff, reload and raise flag same cycle
// - pulse mode counts tick from active edge until level returns, clears run
// - control bit 3 selects edge: 0 rising, 1 falling
// - one measurement only; next needs software to set run again
// - pulse measurement starts on an input edge, never on a level
// - overflow in pulse mode reloads and raises request too
// - bit 4 enables counting; hardware never clears it outside pulse mode
// - overflow wakes the device from halt
// - clearing the irq enable stops servicing, flag still sets
// - preload write also loads counter only while counting is off
// - counter clock blocked during a count read
// - bits 2:0 select tick as system clock over 2 to the field plus one
// - warm reset keeps counter and control; others reset control to 08
//
// The address-and-strobe port was left to the implementer.
module etm_timer (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic warm_rst,
    input wire etm_pkg::etm_req_s req,
    output logic [7:0] rdata,
    input wire logic count_input_and_value,
    input wire logic overflow_irq_enable,
    input wire logic halted,
    output logic overflow_request_flag,
    output logic wake_req,
    output logic divided_freq_output,
    output logic irq
);

    etm_pkg::etm_state_s st_ff;
    etm_pkg::etm_state_s nxt_st;

    // ************************************************************
    // helpers
    // ************************************************************

    // divide-by mask for the prescaler: tick when low bits all ones
    function automatic logic presc_hit(input logic [7:0] cnt, input logic [2:0] sel);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i <= int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return (cnt & m) == m;
    endfunction

    function automatic logic is_active_edge(input logic prev, input logic cur, input logic fall);
        return fall ? (prev && !cur) : (!prev && cur);
    endfunction

    logic [1:0] mode;
    logic run;
    logic edge_fall;
    logic tick;
    logic pin_edge;
    logic rd_count;
    logic wr_count;
    logic wr_ctrl;

    // ************************************************************
    // decode
    // ************************************************************
    always_comb begin
        mode = st_ff.ctrl[etm_pkg::CTRL_MODE_LSB +: 2];
        run = st_ff.ctrl[etm_pkg::CTRL_RUN_BIT];
        edge_fall = st_ff.ctrl[etm_pkg::CTRL_EDGE_BIT];
        // tick is one system cycle each time prescaler bits 0 up to the field value are all ones
        tick = presc_hit(st_ff.presc, st_ff.ctrl[2:0]);
        pin_edge = is_active_edge(st_ff.pin_prev, count_input_and_value, edge_fall);
        rd_count = req.rd && req.addr == etm_pkg::ADDR_COUNT;
        wr_count = req.wr && req.addr == etm_pkg::ADDR_COUNT;
        wr_ctrl = req.wr && req.addr == etm_pkg::ADDR_CTRL;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic inc;
        logic ovf;
        logic meas_end;
        logic [1:0] ev;
        inc = 1'b0;
        ovf = 1'b0;
        meas_end = 1'b0;
        ev = 2'h0;
        nxt_st = st_ff;
        nxt_st.presc = st_ff.presc + 8'h01;
        nxt_st.pin_prev = count_input_and_value;
        nxt_st.tick_prev = tick;
        nxt_st.ovf_flag = 1'b0;
        nxt_st.wake = 1'b0;

        // pick the counting clock for this mode
        case (mode)
            etm_pkg::MODE_EVENT: inc = run && pin_edge;
            etm_pkg::MODE_TIMER: inc = run && tick;
            etm_pkg::MODE_PULSE: begin
                case (st_ff.meas)
                    etm_pkg::ETM_ARMED: begin
                        // start only on a transition, a held level is ignored
                        if (run && pin_edge) begin
                            nxt_st.meas = etm_pkg::ETM_MEASURE;
                        end
                    end
                    etm_pkg::ETM_MEASURE: begin
                        if (count_input_and_value == edge_fall) begin
                            meas_end = 1'b1;
                            nxt_st.meas = etm_pkg::ETM_DONE;
                        end else begin
                            inc = run && tick;
                        end
                    end
                    etm_pkg::ETM_DONE: begin
                        // result held until software sets run again
                        if (run) begin
                            nxt_st.meas = etm_pkg::ETM_ARMED;
                        end
                    end
                    default: nxt_st.meas = etm_pkg::ETM_ARMED;
                endcase
            end
            default: inc = 1'b0;
        endcase
        if (mode != etm_pkg::MODE_PULSE) begin
            nxt_st.meas = etm_pkg::ETM_ARMED;
        end

        // a count read freezes the counter for that cycle; may lose one tick
        if (rd_count) begin
            inc = 1'b0;
        end

        if (inc) begin
            if (st_ff.count == etm_pkg::COUNT_MAX) begin
                ovf = 1'b1;
                nxt_st.count = st_ff.preload;
            end else begin
                nxt_st.count = st_ff.count + 8'h01;
            end
        end

        // register writes
        if (wr_count) begin
            nxt_st.preload = req.wdata;
            if (!run) begin
                nxt_st.count = req.wdata;
            end
        end
        if (wr_ctrl) begin
            nxt_st.ctrl = req.wdata & etm_pkg::CTRL_WMASK;
            if (req.wdata[etm_pkg::CTRL_RUN_BIT]) begin
                if (st_ff.meas == etm_pkg::ETM_DONE) begin
                    nxt_st.meas = etm_pkg::ETM_ARMED;
                end
            end
        end else if (meas_end) begin
            nxt_st.ctrl[etm_pkg::CTRL_RUN_BIT] = 1'b0;
        end

        if (ovf) begin
            nxt_st.ovf_flag = 1'b1;
            nxt_st.freq_out = !st_ff.freq_out;
            nxt_st.wake = halted;
        end

        // sticky status: set wins over write-one-to-clear
        ev[etm_pkg::IRQ_OVF_BIT] = ovf;
        ev[etm_pkg::IRQ_MEAS_BIT] = meas_end;
        if (req.wr && req.addr == etm_pkg::ADDR_IRQ_STATUS) begin
            nxt_st.irq_status = st_ff.irq_status & ~req.wdata[1:0];
        end
        nxt_st.irq_status = nxt_st.irq_status | ev;
        if (req.wr && req.addr == etm_pkg::ADDR_IRQ_MASK) begin
            nxt_st.irq_mask = req.wdata[1:0];
        end

        // read data valid the cycle after the strobe
        nxt_st.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                etm_pkg::ADDR_COUNT: nxt_st.rdata = st_ff.count;
                etm_pkg::ADDR_CTRL: nxt_st.rdata = st_ff.ctrl & etm_pkg::CTRL_WMASK;
                etm_pkg::ADDR_IRQ_STATUS: nxt_st.rdata = {6'h00, st_ff.irq_status};
                etm_pkg::ADDR_IRQ_MASK: nxt_st.rdata = {6'h00, st_ff.irq_mask};
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // warm reset holds counter, preload, control and status; prescaler runs on, flag, wake and read data clear
        if (warm_rst) begin
            nxt_st = st_ff;
            nxt_st.presc = st_ff.presc + 8'h01;
            nxt_st.pin_prev = count_input_and_value;
            nxt_st.ovf_flag = 1'b0;
            nxt_st.wake = 1'b0;
            nxt_st.rdata = 8'h00;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{count: etm_pkg::COUNT_RESET, preload: etm_pkg::COUNT_RESET,
                ctrl: etm_pkg::CTRL_RESET, presc: 8'h00, rdata: 8'h00,
                irq_status: 2'h0, irq_mask: etm_pkg::IRQ_MASK_RESET, pin_prev: 1'b0,
                tick_prev: 1'b0, freq_out: 1'b0, ovf_flag: 1'b0, wake: 1'b0,
                meas: etm_pkg::ETM_ARMED};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata = st_ff.rdata;
    assign divided_freq_output = st_ff.freq_out;
    // request flag pulses; servicing is gated by the enable, flag is not
    assign overflow_request_flag = st_ff.ovf_flag;
    assign wake_req = st_ff.wake;
    assign irq = |(st_ff.irq_status & st_ff.irq_mask) && overflow_irq_enable;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_at_top;
        st_ff.count == etm_pkg::COUNT_MAX && !rd_count && !wr_count && !warm_rst;
    endsequence

    a_timer_reload: assert property (@(posedge clock) disable iff (!arst_n)
        (mode == etm_pkg::MODE_TIMER && run && tick && !wr_ctrl) and s_at_top
        |=> st_ff.count == $past(st_ff.preload) && overflow_request_flag)
        else $error("timer overflow did not reload");
    a_ovf_toggle: assert property (@(posedge clock) disable iff (!arst_n)
        overflow_request_flag |-> divided_freq_output != $past(divided_freq_output))
        else $error("divided output did not toggle");
    a_read_freeze: assert property (@(posedge clock) disable iff (!arst_n)
        rd_count && !wr_count && !warm_rst |=> st_ff.count == $past(st_ff.count))
        else $error("count moved during read");
    a_read_count: assert property (@(posedge clock) disable iff (!arst_n)
        rd_count |=> rdata == $past(st_ff.count))
        else $error("count read wrong");
    a_preload_off: assert property (@(posedge clock) disable iff (!arst_n)
        wr_count && !run && !warm_rst |=> st_ff.count == $past(req.wdata))
        else $error("preload did not load idle counter");
    a_bit5_zero: assert property (@(posedge clock) disable iff (!arst_n)
        !st_ff.ctrl[5])
        else $error("control bit 5 set");
    a_run_kept: assert property (@(posedge clock) disable iff (!arst_n)
        mode != etm_pkg::MODE_PULSE && run && !wr_ctrl |=> run)
        else $error("run cleared by hardware");
    a_pulse_end: assert property (@(posedge clock) disable iff (!arst_n)
        mode == etm_pkg::MODE_PULSE && st_ff.meas == etm_pkg::ETM_MEASURE
        && count_input_and_value == edge_fall && !wr_ctrl && !warm_rst
        |=> !run && st_ff.meas == etm_pkg::ETM_DONE)
        else $error("pulse end missed");
    a_held_result: assert property (@(posedge clock) disable iff (!arst_n)
        st_ff.meas == etm_pkg::ETM_DONE && !run && !req.wr ##1 !req.wr
        |-> st_ff.count == $past(st_ff.count))
        else $error("held result changed");
    a_wake_ovf: assert property (@(posedge clock) disable iff (!arst_n)
        overflow_request_flag && $past(halted) |-> wake_req)
        else $error("no wake on overflow");

    // ************************************************************
    // further checks
    // ************************************************************
    // armed measurement with nothing else steering the phase this cycle
    sequence s_armed;
        mode == etm_pkg::MODE_PULSE && st_ff.meas == etm_pkg::ETM_ARMED && run && !wr_ctrl && !warm_rst;
    endsequence

    // counter left alone by the register port and by warm reset
    sequence s_port_quiet;
        !rd_count && !wr_count && !warm_rst;
    endsequence

    // ticks are single-cycle pulses; the next stage would miss a merged pair
    a_tick_gap: assert property (@(posedge clock) disable iff (!arst_n)
        st_ff.tick_prev |-> !tick)
        else $error("prescaler ticked twice in a row");

    // one active pin edge below the top adds exactly one
    a_event_step: assert property (@(posedge clock) disable iff (!arst_n)
        (mode == etm_pkg::MODE_EVENT && run && pin_edge && st_ff.count != etm_pkg::COUNT_MAX) and s_port_quiet
        |=> st_ff.count == $past(st_ff.count) + 8'h01)
        else $error("event edge not counted");

    // one tick below the top adds exactly one
    a_timer_step: assert property (@(posedge clock) disable iff (!arst_n)
        (mode == etm_pkg::MODE_TIMER && run && tick && st_ff.count != etm_pkg::COUNT_MAX) and s_port_quiet
        |=> st_ff.count == $past(st_ff.count) + 8'h01)
        else $error("tick not counted");

    // the unused mode code must not count
    a_mode_idle: assert property (@(posedge clock) disable iff (!arst_n)
        (mode == etm_pkg::MODE_UNUSED) and s_port_quiet |=> st_ff.count == $past(st_ff.count))
        else $error("unused mode counted");

    // with run off nothing but a write may move the counter,
    // also when software stops a measurement half way
    a_count_off: assert property (@(posedge clock) disable iff (!arst_n)
        (!run) and s_port_quiet |=> st_ff.count == $past(st_ff.count))
        else $error("counter moved with run off");

    // overflow during a measurement reloads like the other modes
    a_pulse_reload: assert property (@(posedge clock) disable iff (!arst_n)
        (mode == etm_pkg::MODE_PULSE && st_ff.meas == etm_pkg::ETM_MEASURE && run && tick
        && count_input_and_value != edge_fall) and s_at_top
        |=> st_ff.count == $past(st_ff.preload) && overflow_request_flag)
        else $error("pulse overflow did not reload");

    // a level that is already active must not start a measurement
    a_level_ignored: assert property (@(posedge clock) disable iff (!arst_n)
        s_armed and (!pin_edge) |=> st_ff.meas == etm_pkg::ETM_ARMED)
        else $error("measurement started on a level");

    a_edge_start: assert property (@(posedge clock) disable iff (!arst_n)
        s_armed and pin_edge |=> st_ff.meas == etm_pkg::ETM_MEASURE)
        else $error("measurement did not start on edge");

    // further edges leave a finished result alone until run is set
    a_done_hold: assert property (@(posedge clock) disable iff (!arst_n)
        mode == etm_pkg::MODE_PULSE && st_ff.meas == etm_pkg::ETM_DONE && !run && !wr_ctrl
        |=> st_ff.meas == etm_pkg::ETM_DONE)
        else $error("finished measurement re-armed");

    // ticks and edges never come in adjacent cycles, so neither do overflows
    a_flag_single: assert property (@(posedge clock) disable iff (!arst_n)
        overflow_request_flag |=> !overflow_request_flag)
        else $error("request flag longer than one cycle");

    // the sticky bit is already set while the pulse stands
    a_status_set: assert property (@(posedge clock) disable iff (!arst_n)
        overflow_request_flag |-> st_ff.irq_status[etm_pkg::IRQ_OVF_BIT])
        else $error("overflow status not set");

    a_irq_gate: assert property (@(posedge clock) disable iff (!arst_n)
        !overflow_irq_enable |-> !irq)
        else $error("irq with enable cleared");

    // the buzzer output moves only on an overflow
    a_freq_cause: assert property (@(posedge clock) disable iff (!arst_n)
        $changed(divided_freq_output) |-> overflow_request_flag)
        else $error("divided output moved without overflow");

    a_wake_cause: assert property (@(posedge clock) disable iff (!arst_n)
        wake_req |-> overflow_request_flag && $past(halted))
        else $error("wake without overflow in halt");

    // warm reset must not disturb a measurement or a running count
    a_warm_hold: assert property (@(posedge clock) disable iff (!arst_n)
        warm_rst |=> st_ff.count == $past(st_ff.count) && st_ff.ctrl == $past(st_ff.ctrl)
        && st_ff.preload == $past(st_ff.preload))
        else $error("warm reset changed timer state");

    // while running a write reaches the preload only
    a_preload_on: assert property (@(posedge clock) disable iff (!arst_n)
        wr_count && run && !warm_rst |=> st_ff.preload == $past(req.wdata))
        else $error("preload write lost");

    // read data stand for one cycle only, then fall back to zero
    a_rdata_idle: assert property (@(posedge clock) disable iff (!arst_n)
        !req.rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");

endmodule // etm_timer

/* File: bench/etm_pin_model.sv */
// ************************************************************
// far-side pin: bursts of pulses around a chosen idle level
// ************************************************************
module etm_pin_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic idle_lvl,
    input wire logic [7:0] n_pulses,
    input wire logic [7:0] width,
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_ff;
    logic [7:0] cnt_ff;
    // active phase first, then idle phase; the line rests at idle_lvl like a pulled pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin <= 1'b0;
            busy <= 1'b0;
            cnt_ff <= 8'h00;
            left_ff <= 8'h00;
        end else if (start && !busy) begin
            pin <= ~idle_lvl;
            busy <= (n_pulses != 8'h00);
            cnt_ff <= 8'h00;
            left_ff <= n_pulses;
        end else if (busy) begin
            cnt_ff <= cnt_ff + 8'h01;
            if (cnt_ff == width - 8'h01) begin
                cnt_ff <= 8'h00;
                if (pin != idle_lvl) begin
                    left_ff <= left_ff - 8'h01;
                    busy <= (left_ff != 8'h01);
                    pin <= idle_lvl;
                end else begin
                    pin <= ~idle_lvl;
                end
            end
        end else begin
            pin <= idle_lvl;
        end
    end
endmodule // etm_pin_model

/* File: bench/etm_timer_tb.sv */
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD %0t %s got %0h exp %0h", $time, tname, (got), (exp)); \
    end \
end
module etm_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_CNT = etm_pkg::ADDR_COUNT;
    localparam logic [7:0] A_CTL = etm_pkg::ADDR_CTRL;
    localparam logic [7:0] A_ST = etm_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] A_MSK = etm_pkg::ADDR_IRQ_MASK;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic warm_rst = 1'b0;
    etm_pkg::etm_req_s req = '0;
    logic [7:0] rdata;
    logic pin, pin_busy, flag, wake, freq, irq, f_prev, f_last;
    logic pin_start = 1'b0;
    logic idle_lvl = 1'b0;
    logic irq_ena = 1'b0;
    logic halted = 1'b0;
    logic [7:0] n_pulses = 8'h01;
    logic [7:0] width = 8'h04;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int nflag = 0;
    int nwake = 0;
    int t_prev = 0;
    int t_last = 0;
    string tname = "none";

    initial begin
        forever #2 clock = ~clock;
    end

    etm_timer i_etm_timer (.clock(clock), .arst_n(arst_n), .warm_rst(warm_rst), .req(req), .rdata(rdata),
        .count_input_and_value(pin), .overflow_irq_enable(irq_ena), .halted(halted),
        .overflow_request_flag(flag), .wake_req(wake), .divided_freq_output(freq), .irq(irq));
    etm_pin_model i_etm_pin_model (.clock(clock), .arst_n(arst_n), .start(pin_start), .idle_lvl(idle_lvl),
        .n_pulses(n_pulses), .width(width), .pin(pin), .busy(pin_busy));

    // ************************************************************
    // monitor: overflow times, output level at each, wake pulses, hang guard
    // ************************************************************
    // falling edge: registered outputs have settled, no race with their launch edge
    always @(negedge clock) begin
        cyc++;
        if (flag === 1'b1) begin
            nflag++;
            t_prev = t_last;
            t_last = cyc;
            f_prev = f_last;
            f_last = freq;
        end
        if (wake === 1'b1) nwake++;
        if (cyc == 20000) begin
            errors++;
            $display("BAD %0t hang", $time);
            finish_test();
        end
    end

    // ************************************************************
    // register port and pin helpers
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock);
        req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wait_flags(input int n);
        int t = nflag + n;
        for (int i = 0; i < 4000 && nflag < t; i++) @(posedge clock);
        `CHK(nflag >= t, 1'b1)
    endtask
    task automatic go(input logic [7:0] n, input logic [7:0] w);
        @(posedge clock);
        n_pulses <= n;
        width <= w;
        pin_start <= 1'b1;
        @(posedge clock);
        pin_start <= 1'b0;
    endtask
    task automatic done();
        #1;
        for (int i = 0; i < 2000 && pin_busy === 1'b1; i++) @(posedge clock);
        waitc(4);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        tname = "reset";
        rchk(A_CTL, 8'h08);
        rchk(A_CNT, 8'h00);
        rchk(8'h20, 8'h00);
        wr(A_CTL, 8'h2f);
        rchk(A_CTL, 8'h0f);
        `CHK(freq, 1'b0)
        $display("test %s done", tname);
    endtask
    task automatic t_event();
        tname = "event";
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'hfd);
        rchk(A_CNT, 8'hfd);
        wr(A_CTL, 8'h50);
        go(8'h03, 8'h04);
        done();
        `CHK(nflag, 1)
        rchk(A_CNT, 8'hfd);
        wr(A_CNT, 8'h80);
        rchk(A_CNT, 8'hfd);
        rchk(A_CTL, 8'h50);
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'h10);
        wr(A_CTL, 8'h10);
        go(8'h02, 8'h04);
        done();
        rchk(A_CNT, 8'h10);
        $display("test %s done", tname);
    endtask
    // preload fe gives two ticks between overflows
    task automatic t_timer();
        tname = "timer";
        for (int s = 0; s < 8; s++) begin
            wr(A_CTL, 8'h00);
            wr(A_CNT, 8'hfe);
            wr(A_CTL, 8'h90 | 8'(s));
            wait_flags(3);
            rchk(A_CTL, 8'h90 | 8'(s));
            `CHK(t_last - t_prev, 4 << s)
            `CHK(f_last, ~f_prev)
        end
        $display("test %s done", tname);
    endtask
    task automatic t_irq();
        tname = "irq";
        wr(A_CTL, 8'h00);
        wr(A_ST, 8'h03);
        wr(A_CNT, 8'h00);
        halted <= 1'b1;
        nwake = 0;
        wr(A_CTL, 8'h90);
        wait_flags(1);
        wr(A_CTL, 8'h00);
        halted <= 1'b0;
        `CHK(nwake, 1)
        `CHK(irq, 1'b0)
        irq_ena <= 1'b1;
        wr(A_MSK, 8'h01);
        #1 `CHK(irq, 1'b1)
        @(posedge clock);
        irq_ena <= 1'b0;
        #1 `CHK(irq, 1'b0)
        rchk(A_ST, 8'h01);
        irq_ena <= 1'b1;
        wr(A_ST, 8'h01);
        #1 `CHK(irq, 1'b0)
        rchk(A_ST, 8'h00);
        $display("test %s done", tname);
    endtask
    // both edge selections; run set while the pin already sits active must not start
    task automatic t_pulse();
        logic [7:0] m;
        int n0;
        tname = "pulse";
        for (int e = 0; e < 2; e++) begin
            m = 8'(e << 3);
            @(posedge clock);
            idle_lvl <= e[0];
            wr(A_CTL, 8'h00);
            wr(A_CNT, 8'h00);
            wr(A_ST, 8'h03);
            go(8'h01, 8'h28);
            wr(A_CTL, 8'hd0 | m);
            done();
            rchk(A_CNT, 8'h00);
            rchk(A_CTL, 8'hd0 | m);
            go(8'h02, 8'h14);
            done();
            @(posedge clock);
            req.addr <= A_CNT;
            req.rd <= 1'b1;
            @(posedge clock);
            req.rd <= 1'b0;
            #1 `CHK(rdata >= 8'h09 && rdata <= 8'h0b, 1'b1)
            rchk(A_CTL, 8'hc0 | m);
            rchk(A_ST, 8'h02);
        end
        // preload f8: about ten ticks of measurement pass the top once
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'hf8);
        wr(A_ST, 8'h03);
        wr(A_CTL, 8'hd8);
        n0 = nflag;
        go(8'h01, 8'h14);
        done();
        `CHK(nflag - n0, 1)
        rchk(A_ST, 8'h03);
        $display("test %s done", tname);
    endtask
    task automatic t_warm();
        logic f0;
        tname = "warm";
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'h5a);
        wr(A_CTL, 8'h87);
        f0 = freq;
        warm_rst <= 1'b1;
        waitc(3);
        warm_rst <= 1'b0;
        rchk(A_CNT, 8'h5a);
        rchk(A_CTL, 8'h87);
        `CHK(freq, f0)
        $display("test %s done", tname);
    endtask

    task automatic finish_test();
        $display("counts: %0d checks, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_event();
        t_timer();
        t_irq();
        t_pulse();
        t_warm();
        finish_test();
    end
endmodule // etm_timer_tb
